// *** verilog/ahts_defs.svh ***
// register offsets, field positions, reset values and counts of the trigger-wait sequencer
`ifndef AHTS_DEFS_SVH
`define AHTS_DEFS_SVH
`define AHTS_OFF_CTRL 12'h000
`define AHTS_OFF_CHSEL 12'h004
`define AHTS_OFF_RESULT 12'h008
`define AHTS_OFF_ISTAT 12'h00C
`define AHTS_OFF_IMASK 12'h010
`define AHTS_OFF_STATUS 12'h014
`define AHTS_CTRL_EN 0
`define AHTS_CTRL_START 1
`define AHTS_CTRL_SCAN 2
`define AHTS_CTRL_CONT 3
`define AHTS_IRQ_END 0
`define AHTS_ST_PWR 4
`define AHTS_ST_IDX 2
`define AHTS_RST_CHSEL 32'h0000_0000
`define AHTS_RST_MASK 1'h0
`define AHTS_SCAN_LAST 2'h3
`endif

// *** verilog/ahts_pkg.sv ***
// types of the trigger-wait sequencer
package ahts_pkg;
    typedef enum logic [1:0] {
        AHTS_STOP,
        AHTS_WAIT,
        AHTS_CONV
    } ahts_state_t;
    typedef struct packed {
        logic cont;
        logic scan;
        logic en;
    } ahts_ctrl_t;
    typedef struct packed {
        logic start;
        logic abort;
    } ahts_cmd_t;
endpackage : ahts_pkg

// *** verilog/ahts_seq.sv ***
// hardware-trigger wait sequencer of the converter, with APB registers
`timescale 1ns/1ps
`include "ahts_defs.svh"
module ahts_seq
    import ahts_pkg::*;
#(
    parameter int CH_W = 5,
    parameter int RES_W = 12
) (
    input wire logic mclk, // 200 MHz clock
    input wire logic rst_b, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped
    input wire logic hwTrig, // trigger pin
    input wire logic convDone, // core conversion finished
    input wire logic [RES_W-1:0] convData, // core result
    output logic convStart, // start core on convChan
    output logic convAbort, // abort running conversion
    output logic [CH_W-1:0] convChan, // channel for core
    output logic convPower, // core running, low in stop and wait
    output logic convEndIrq, // end-of-conversion pulse
    output logic irq // masked interrupt level
);
    ahts_state_t state_q, state_d;
    ahts_ctrl_t ctrl_q;
    ahts_cmd_t cmd_d;
    logic start_q, start_d;
    logic [1:0] idx_q, idx_d;
    logic [CH_W-1:0] chsel_q;
    logic [RES_W-1:0] result_q;
    logic stat_q, mask_q;
    logic trigS1_q, trigS2_q, trigPrev_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic convStart_q, convAbort_q, convPower_q, power_d;
    logic convEndIrq_q, irq_q, endEv;
    logic [CH_W-1:0] convChan_q;

    // apb decode
    wire setupPh = psel & ~penable;
    wire wrAcc = psel & penable & pwrite & pready_q;
    wire hitCtrl = paddr == `AHTS_OFF_CTRL;
    wire hitChsel = paddr == `AHTS_OFF_CHSEL;
    wire hitResult = paddr == `AHTS_OFF_RESULT;
    wire hitIstat = paddr == `AHTS_OFF_ISTAT;
    wire hitImask = paddr == `AHTS_OFF_IMASK;
    wire hitStatus = paddr == `AHTS_OFF_STATUS;
    wire hitAny = hitCtrl | hitChsel | hitResult | hitIstat | hitImask | hitStatus;
    wire wrCtrl = wrAcc & hitCtrl;
    wire wrChsel = wrAcc & hitChsel;
    wire wrIstat = wrAcc & hitIstat;
    wire wrImask = wrAcc & hitImask;

    // control values as they stand after this cycle's write
    wire enNext = wrCtrl ? pwdata[`AHTS_CTRL_EN] : ctrl_q.en;
    wire scanNext = wrCtrl ? pwdata[`AHTS_CTRL_SCAN] : ctrl_q.scan;
    wire contNext = wrCtrl ? pwdata[`AHTS_CTRL_CONT] : ctrl_q.cont;
    wire [CH_W-1:0] chselNext = wrChsel ? pwdata[CH_W-1:0] : chsel_q;
    wire startOne = wrCtrl & pwdata[`AHTS_CTRL_START];
    wire startZero = wrCtrl & ~pwdata[`AHTS_CTRL_START];

    // trigger rising edge after the synchroniser
    wire trigEdge = trigS2_q & ~trigPrev_q;
    wire restartEv = trigEdge | wrChsel | startOne;
    wire lastConv = ~scanNext | (idx_q == `AHTS_SCAN_LAST);

    // channel handed to the core: base plus scan position
    wire [CH_W-1:0] idxWide = {{(CH_W-2){1'b0}}, idx_d};
    wire [CH_W-1:0] chanNext = scanNext ? CH_W'(chselNext + idxWide) : chselNext;

    // read mux
    wire [31:0] ctrlRd = {28'h0000000, ctrl_q.cont, ctrl_q.scan, start_q, ctrl_q.en};
    wire [31:0] statusRd = {27'h0000000, convPower_q, idx_q, state_q};
    wire [31:0] rdMux = hitCtrl ? ctrlRd
        : hitChsel ? 32'(chsel_q)
        : hitResult ? 32'(result_q)
        : hitIstat ? {31'h00000000, stat_q}
        : hitImask ? {31'h00000000, mask_q}
        : hitStatus ? statusRd
        : 32'h0000_0000;

    always_comb begin
        state_d = state_q;
        start_d = start_q;
        idx_d = idx_q;
        power_d = convPower_q;
        cmd_d = '0;
        endEv = 1'b0;
        case (state_q)
            AHTS_STOP: begin
                start_d = 1'b0;
                power_d = 1'b0;
                if (enNext) begin
                    state_d = AHTS_WAIT;
                end
            end
            AHTS_WAIT: begin
                power_d = 1'b0;
                start_d = 1'b0;
                if (!enNext) begin
                    state_d = AHTS_STOP;
                end else if (trigEdge) begin
                    state_d = AHTS_CONV;
                    start_d = 1'b1;
                    idx_d = 2'h0;
                    power_d = 1'b1;
                    cmd_d.start = 1'b1;
                end
            end
            AHTS_CONV: begin
                if (!enNext) begin
                    state_d = AHTS_STOP;
                    start_d = 1'b0;
                    power_d = 1'b0;
                    cmd_d.abort = 1'b1;
                end else if (startZero) begin
                    state_d = AHTS_WAIT;
                    start_d = 1'b0;
                    power_d = 1'b0;
                    cmd_d.abort = 1'b1;
                end else if (restartEv) begin
                    idx_d = 2'h0;
                    cmd_d.abort = 1'b1;
                    cmd_d.start = 1'b1;
                end else if (convDone) begin
                    endEv = 1'b1;
                    if (!lastConv) begin
                        idx_d = 2'(idx_q + 2'h1);
                        cmd_d.start = 1'b1;
                    end else if (contNext) begin
                        idx_d = 2'h0;
                        cmd_d.start = 1'b1;
                    end else begin
                        state_d = AHTS_WAIT;
                        start_d = 1'b0;
                        power_d = 1'b0;
                        idx_d = 2'h0;
                    end
                end
            end
            default: begin
                state_d = AHTS_STOP;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= AHTS_STOP;
            start_q <= 1'b0;
            idx_q <= 2'h0;
            convPower_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_q <= start_d;
            idx_q <= idx_d;
            convPower_q <= power_d;
        end
    end

    // core commands and end pulse
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            convStart_q <= 1'b0;
            convAbort_q <= 1'b0;
            convChan_q <= '0;
            convEndIrq_q <= 1'b0;
        end else begin
            convStart_q <= cmd_d.start;
            convAbort_q <= cmd_d.abort;
            convEndIrq_q <= endEv;
            if (cmd_d.start) begin
                convChan_q <= chanNext;
            end
        end
    end

    // result store
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= '0;
        end else if (endEv) begin
            result_q <= convData;
        end
    end

    // trigger synchroniser and edge history
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trigS1_q <= 1'b0;
            trigS2_q <= 1'b0;
            trigPrev_q <= 1'b0;
        end else begin
            trigS1_q <= hwTrig;
            trigS2_q <= trigS1_q;
            trigPrev_q <= trigS2_q;
        end
    end

    // software-written registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= '0;
            chsel_q <= CH_W'(`AHTS_RST_CHSEL);
            mask_q <= `AHTS_RST_MASK;
        end else begin
            if (wrCtrl) begin
                ctrl_q.en <= pwdata[`AHTS_CTRL_EN];
                ctrl_q.scan <= pwdata[`AHTS_CTRL_SCAN];
                ctrl_q.cont <= pwdata[`AHTS_CTRL_CONT];
            end
            if (wrChsel) begin
                chsel_q <= pwdata[CH_W-1:0];
            end
            if (wrImask) begin
                mask_q <= pwdata[`AHTS_IRQ_END];
            end
        end
    end

    // sticky status, set wins over write-one clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= endEv | (stat_q & ~(wrIstat & pwdata[`AHTS_IRQ_END]));
            irq_q <= stat_q & mask_q;
        end
    end

    // apb answer: one wait-free access phase
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setupPh;
            pslverr_q <= setupPh & ~hitAny;
            prdata_q <= (setupPh & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign convStart = convStart_q;
    assign convAbort = convAbort_q;
    assign convChan = convChan_q;
    assign convPower = convPower_q;
    assign convEndIrq = convEndIrq_q;
    assign irq = irq_q;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    wire inConv = state_q == AHTS_CONV;
    wire quietConv = inConv & enNext & ~startZero & ~restartEv;

    sequence s_trigInWait;
        state_q == AHTS_WAIT && enNext && trigEdge;
    endsequence

    sequence s_doneQuiet;
        quietConv && convDone;
    endsequence

    sequence s_restartIssued;
        convAbort && convStart && idx_q == 2'h0 && state_q == AHTS_CONV;
    endsequence

    chk_enable_standby: assert property (
        (state_q == AHTS_STOP && wrCtrl && pwdata[`AHTS_CTRL_EN])
        |=> state_q == AHTS_WAIT && !convStart && !convPower)
        else $error("enable from stop did not reach standby");

    chk_trig_start: assert property (
        s_trigInWait |=> inConv && start_q && convStart && !convAbort
        && convChan == $past(chanNext))
        else $error("trigger in standby did not start conversion");

    chk_done_store: assert property (
        s_doneQuiet |=> convEndIrq && result_q == $past(convData) && stat_q)
        else $error("conversion end not stored or signalled");

    chk_single_stop: assert property (
        (s_doneQuiet and (lastConv && !contNext))
        |=> state_q == AHTS_WAIT && !start_q && !convPower ##1 !convStart)
        else $error("single conversion did not stop");

    chk_trig_restart: assert property (
        (inConv && enNext && !startZero && trigEdge) |=> s_restartIssued)
        else $error("trigger during conversion did not restart");

    chk_chsel_restart: assert property (
        (inConv && enNext && !startZero && wrChsel)
        |=> s_restartIssued ##0 convChan == $past(pwdata[CH_W-1:0]))
        else $error("channel write did not restart on new channel");

    chk_start_restart: assert property (
        (inConv && enNext && startOne) |=> s_restartIssued and start_q)
        else $error("start write one did not restart");

    chk_stop_write: assert property (
        (inConv && enNext && startZero)
        |=> state_q == AHTS_WAIT && convAbort && !start_q && !convPower)
        else $error("start write zero did not abort to standby");

    chk_disabled_idle: assert property (
        (!ctrl_q.en && state_q != AHTS_CONV) |=> !convStart)
        else $error("conversion began while disabled");

    chk_scan_step: assert property (
        (s_doneQuiet and (!lastConv))
        |=> convStart && idx_q == 2'($past(idx_q) + 2'h1)
        && convChan == CH_W'($past(chsel_q) + {{(CH_W-2){1'b0}}, idx_q}))
        else $error("scan did not advance to next channel");

    chk_scan_irq: assert property (
        (s_doneQuiet and (scanNext)) |=> convEndIrq ##1 !convEndIrq)
        else $error("scan channel end did not pulse interrupt");

    chk_scan_wrap: assert property (
        (s_doneQuiet and (scanNext && lastConv && contNext))
        |=> inConv && convStart && idx_q == 2'h0 && convChan == $past(chsel_q))
        else $error("continuous scan did not wrap at once");

    chk_scan_trig: assert property (
        (inConv && scanNext && enNext && !startZero && trigEdge && !wrChsel)
        |=> s_restartIssued ##0 convChan == $past(chsel_q))
        else $error("scan trigger did not restart from first channel");

    chk_scan_chsel: assert property (
        (inConv && scanNext && enNext && !startZero && wrChsel)
        |=> idx_q == 2'h0 && convChan == $past(pwdata[CH_W-1:0]))
        else $error("scan channel write did not restart from new base");

    chk_scan_start: assert property (
        (inConv && scanNext && enNext && startOne && !wrChsel)
        |=> s_restartIssued ##0 convChan == $past(chsel_q))
        else $error("scan start write did not restart from first channel");

    chk_trig_pulse: assert property (
        trigEdge |=> !trigEdge)
        else $error("trigger event longer than one cycle");
endmodule : ahts_seq

// *** verification/ahts_core_model.sv ***
// conversion core model answering start and abort pulses of the sequencer
`timescale 1ns/1ps
module ahts_core_model #(
    parameter int LAT = 20
) (
    input wire logic mclk, // clock
    input wire logic rst_b, // async reset, low
    input wire logic convStart, // start pulse
    input wire logic convAbort, // abort pulse
    input wire logic [4:0] convChan, // channel to convert
    output logic convDone, // done pulse
    output logic [11:0] convData // result, valid with done only
);
    int cnt_q;
    logic [4:0] chan_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 0;
            chan_q <= 5'h00;
            convDone <= 1'b0;
            convData <= 12'h000;
        end else begin
            convDone <= 1'b0;
            // data toggles outside the done cycle so a late sample shows up
            convData <= ~convData;
            if (convStart) begin
                cnt_q <= LAT;
                chan_q <= convChan;
            end else if (convAbort) begin
                cnt_q <= 0;
            end else if (cnt_q == 1) begin
                cnt_q <= 0;
                convDone <= 1'b1;
                convData <= {7'h50, chan_q};
            end else if (cnt_q > 1) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : ahts_core_model

// *** verification/ahts_seq_tb.sv ***
// self-checking bench of the trigger-wait sequencer
`timescale 1ns/1ps
`include "ahts_defs.svh"
module ahts_seq_tb
    import ahts_pkg::*;
;
    typedef struct packed {logic scan; logic cont; logic [4:0] base; logic [3:0] n;} ahts_row_t;
    localparam ahts_row_t ROWS [4] = '{'{1'b0, 1'b0, 5'h03, 4'h1}, '{1'b0, 1'b1, 5'h1F, 4'h3},
        '{1'b1, 1'b0, 5'h08, 4'h4}, '{1'b1, 1'b1, 5'h1C, 4'h6}};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic hwTrig = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, slvErr, convDone, convStart, convAbort, convPower, convEndIrq, irq;
    logic [11:0] convData;
    logic [4:0] convChan;
    logic [4:0] chanQ [$];
    int errCount = 0;
    int totalChecks = 0;
    int irqCnt = 0;
    int abortCnt = 0;
    int sz;
    always #2.5 mclk = ~mclk;
    ahts_seq #(.CH_W(5), .RES_W(12)) i_ahts_seq (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hwTrig(hwTrig), .convDone(convDone), .convData(convData), .convStart(convStart),
        .convAbort(convAbort), .convChan(convChan), .convPower(convPower), .convEndIrq(convEndIrq), .irq(irq));
    ahts_core_model #(.LAT(20)) i_ahts_core_model (.mclk(mclk), .rst_b(rst_b), .convStart(convStart),
        .convAbort(convAbort), .convChan(convChan), .convDone(convDone), .convData(convData));
    always @(posedge mclk) begin
        if (convStart === 1'b1) chanQ.push_back(convChan);
        if (convAbort === 1'b1) abortCnt++;
        if (convEndIrq === 1'b1) irqCnt++;
    end
    task automatic finishTest();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finishTest
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkWord
    task automatic chkFlag(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkFlag
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        slvErr = pslverr;
        if (n >= 50) begin
            errCount++;
            finishTest();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic trig();
        @(posedge mclk);
        hwTrig <= 1'b1;
        repeat (4) @(posedge mclk);
        hwTrig <= 1'b0;
    endtask : trig
    task automatic waitIrq(input int n);
        for (int k = 0; k < 3000 && irqCnt < n; k++) @(posedge mclk);
        if (irqCnt < n) begin
            errCount++;
            finishTest();
        end
    endtask : waitIrq
    function automatic logic [31:0] expCh(input logic [4:0] b, input logic s, input int i);
        return {27'h0, b + (s ? 5'(i % 4) : 5'h00)};
    endfunction : expCh
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 12'(k * 4), 32'h0000_0000);
            chkWord(rd, 32'h0000_0000);
            chkFlag(slvErr, 1'b0);
        end
        apb(1'b0, 12'h040, 32'h0000_0000);
        chkFlag(slvErr, 1'b1);
        trig();
        repeat (10) @(posedge mclk);
        chkWord(32'(chanQ.size()), 32'h0000_0000);
        $display("test reset done");
        foreach (ROWS[r]) begin
            chanQ.delete();
            irqCnt = 0;
            apb(1'b1, `AHTS_OFF_CHSEL, {27'h0, ROWS[r].base});
            apb(1'b1, `AHTS_OFF_CTRL, {28'h0, ROWS[r].cont, ROWS[r].scan, 2'b01});
            apb(1'b0, `AHTS_OFF_STATUS, 32'h0000_0000);
            chkWord(rd & 32'h0000_0013, 32'h0000_0001);
            trig();
            waitIrq(ROWS[r].n);
            apb(1'b0, `AHTS_OFF_RESULT, 32'h0000_0000);
            chkWord(rd, 32'h0000_0A00 | expCh(ROWS[r].base, ROWS[r].scan, ROWS[r].n - 1));
            for (int i = 0; i < ROWS[r].n; i++) chkWord({27'h0, chanQ[i]}, expCh(ROWS[r].base, ROWS[r].scan, i));
            apb(1'b0, `AHTS_OFF_CTRL, 32'h0000_0000);
            chkFlag(rd[1], ROWS[r].cont);
            chkFlag(convPower, ROWS[r].cont);
            apb(1'b1, `AHTS_OFF_CTRL, {28'h0, ROWS[r].cont, ROWS[r].scan, 2'b01});
            apb(1'b0, `AHTS_OFF_STATUS, 32'h0000_0000);
            chkWord(rd & 32'h0000_0013, 32'h0000_0001);
            sz = chanQ.size();
            repeat (30) @(posedge mclk);
            chkWord(32'(chanQ.size()), 32'(sz));
            apb(1'b1, `AHTS_OFF_CTRL, 32'h0000_0000);
            $display("test row %0d done", r);
        end
        chkFlag(irq, 1'b0);
        apb(1'b1, `AHTS_OFF_IMASK, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chkFlag(irq, 1'b1);
        apb(1'b1, `AHTS_OFF_ISTAT, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chkFlag(irq, 1'b0);
        $display("test interrupt done");
        for (int m = 0; m < 6; m++) begin
            chanQ.delete();
            irqCnt = 0;
            apb(1'b1, `AHTS_OFF_CHSEL, 32'h0000_0004);
            apb(1'b1, `AHTS_OFF_CTRL, {28'h0, 1'b1, 1'(m / 3), 2'b01});
            trig();
            waitIrq(1);
            // snapshot late: the previous pass's closing abort is counted one edge after its write
            sz = abortCnt;
            if (m % 3 == 0) trig();
            else if (m % 3 == 1) apb(1'b1, `AHTS_OFF_CHSEL, 32'h0000_000A);
            else apb(1'b1, `AHTS_OFF_CTRL, {28'h0, 1'b1, 1'(m / 3), 2'b11});
            repeat (6) @(posedge mclk);
            chkWord(32'(abortCnt - sz), 32'h0000_0001);
            chkWord(32'(chanQ.size()), 32'h0000_0003);
            chkWord({27'h0, chanQ[2]}, (m % 3 == 1) ? 32'h0000_000A : 32'h0000_0004);
            apb(1'b1, `AHTS_OFF_CTRL, 32'h0000_0000);
            $display("test restart %0d done", m);
        end
        apb(1'b1, `AHTS_OFF_CTRL, 32'h0000_0009);
        trig();
        chkFlag(convPower, 1'b1);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        chkFlag(convPower, 1'b0);
        chkFlag(convStart, 1'b0);
        rst_b <= 1'b1;
        apb(1'b0, `AHTS_OFF_STATUS, 32'h0000_0000);
        chkWord(rd, 32'h0000_0000);
        apb(1'b0, `AHTS_OFF_CTRL, 32'h0000_0000);
        chkWord(rd, 32'h0000_0000);
        $display("test mid-run reset done");
        finishTest();
    end
endmodule : ahts_seq_tb
